// [design/sepa_top.sv]
`timescale 1ns/1ps
module sepa_top #(
  parameter int WR_CYCLE_CYC = sepa_pkg::WR_CYCLE_CYC
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // serial link, mode 0
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // protection pin and nonvolatile protection bits
  input wire logic wp_n_i,
  input wire logic block_protect_lo_i,
  input wire logic block_protect_hi_i,
  input wire logic hw_protect_arm_bit_i,
  // state seen by the system
  output logic busy_o,
  output logic write_latch_o,
  output logic status_write_ok_o
);
  import sepa_pkg::*;

  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(WR_CYCLE_CYC - 1);

  // system domain state
  typedef struct packed {
    sepa_wc_e st;                   // write-cycle sequencer
    logic [PAGE_W-1:0] idx;         // byte being copied
    logic [WAIT_W-1:0] wait_cnt;    // self-timed delay
    logic [PAGE_NUM_W-1:0] page;    // page being programmed
    logic wel;                      // write enable latch
    logic cs_n_d;                   // previous synced select
    logic set_write_latch_cmd_t;                   // last seen set-latch toggle
    logic busy;                     // write cycle running
    logic swok;                     // status register writable
    logic [7:0] stat;               // status byte for the link
  } sepa_sys_s;

  // link domain state
  typedef struct packed {
    sepa_link_e ph;                 // frame phase
    logic [4:0] cnt;                // bit index within phase
    logic [23:0] sh;                // input shift register
    logic [ADDR_W-1:0] addr;        // read address
    logic is_wr;                    // address belongs to a write
    logic [PAGE_W-1:0] wptr;        // page offset for next data byte
    logic [PAGE_NUM_W-1:0] wpage;   // page of the write
    logic wr_ok;                    // last edge completed a data byte
    logic set_write_latch_cmd_t;                   // toggles once per set-latch command taken while not busy
  } sepa_lnk_s;

  // link output state, falling edge
  typedef struct packed {
    logic so;
    logic oe;
    logic [7:0] osh;
  } sepa_out_s;

  sepa_sys_s sq, sd;
  sepa_lnk_s lq, ld, c;
  sepa_out_s oq, od;
  logic fresh_q;                    // frame not yet clocked
  logic frame_rst;                  // select high or reset
  logic [6:0] sys_raw, sys_s;       // inputs to system domain
  logic cs_s, wp_s, bp_lo_s, bp_hi_s, arm_s, set_write_latch_cmd_s, wrok_s;
  logic [7:0] stat_k;               // status byte seen by the link
  logic busy_k, wel_k;
  logic [23:0] bit_in;              // shift register with current bit
  logic [7:0] cmd;                  // masked opcode
  logic buf_we;
  logic [7:0] mem_rd;
  logic cs_rise, set_write_latch_cmd_ev, prot;

  // protected range by protect level
  function automatic logic sepa_prot(input logic [1:0] bp, input logic [PAGE_NUM_W-1:0] pg);
    logic r;
    r = 1'b0;
    unique case (bp)
      2'b00: r = 1'b0;
      2'b01: r = (pg[PAGE_NUM_W-1 -: 2] == 2'b11);
      2'b10: r = pg[PAGE_NUM_W-1];
      2'b11: r = 1'b1;
    endcase
    return r;
  endfunction

  // ---------------- system domain ----------------

  // pins and link flags into the system clock
  // select and pin go in inverted so the synchroniser's reset value matches their idle level
  assign sys_raw = {!cs_n_i, !wp_n_i, block_protect_lo_i, block_protect_hi_i, hw_protect_arm_bit_i, lq.set_write_latch_cmd_t, lq.wr_ok};
  sepa_sync #(.W(7)) u_sys_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(sys_raw),
    .q_o(sys_s)
  );
  // no false select rise right after reset
  assign cs_s = !sys_s[6];
  assign wp_s = !sys_s[5];
  assign {bp_lo_s, bp_hi_s, arm_s, set_write_latch_cmd_s, wrok_s} = sys_s[4:0];

  // next state of the write-cycle sequencer and latch
  always_comb begin
    sd = sq;
    cs_rise = cs_s && !sq.cs_n_d;
    set_write_latch_cmd_ev = (set_write_latch_cmd_s != sq.set_write_latch_cmd_t);
    // page number is stable: the link clock has stopped by the time the rise is seen
    prot = sepa_prot({bp_hi_s, bp_lo_s}, lq.wpage);
    sd.cs_n_d = cs_s;
    sd.set_write_latch_cmd_t = set_write_latch_cmd_s;
    unique case (sq.st)
      WC_IDLE: begin
        // start only at select rise, with a byte-aligned frame and the latch set
        if (cs_rise && wrok_s && sq.wel && !prot) begin
          sd.st = WC_COPY;
          sd.idx = '0;
          sd.page = lq.wpage;
        end
      end
      WC_COPY: begin
        // the whole buffer goes in, short frames leave stale bytes
        sd.idx = PAGE_W'(sq.idx + 7'h01);
        if (sq.idx == PAGE_IDX_LAST) begin
          sd.st = WC_WAIT;
          sd.wait_cnt = '0;
        end
      end
      WC_WAIT: begin
        sd.wait_cnt = WAIT_W'(sq.wait_cnt + 20'h00001);
        if (sq.wait_cnt == WAIT_LAST) begin
          sd.st = WC_IDLE;
          sd.wel = 1'b0;
        end
      end
    endcase
    // a set arriving with the clear wins
    if (set_write_latch_cmd_ev) begin
      sd.wel = 1'b1;
    end
    sd.busy = (sd.st != WC_IDLE);
    // status register write needs the latch and either arm clear or pin high
    sd.swok = sd.wel && (!arm_s || wp_s);
    if (sd.busy) begin
      sd.stat = STAT_BUSY_ALL;
    end else begin
      sd.stat = {arm_s, 3'b000, bp_hi_s, bp_lo_s, sd.wel, 1'b0};
    end
  end

  // system domain register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sq <= '{st: WC_IDLE, idx: '0, wait_cnt: '0, page: '0, wel: 1'b0, cs_n_d: 1'b1,
              set_write_latch_cmd_t: 1'b0, busy: 1'b0, swok: 1'b0, stat: STAT_RESET};
    end else begin
      sq <= sd;
    end
  end

  assign busy_o = sq.busy;
  assign write_latch_o = sq.wel;
  assign status_write_ok_o = sq.swok;

  // ---------------- link domain ----------------

  // status byte into the link clock; a tear lasts one edge at most
  sepa_sync #(.W(8)) u_lnk_sync (
    .clk_i(sck_i),
    .rst_n_i(rst_n_i),
    .d_i(sq.stat),
    .q_o(stat_k)
  );
  assign busy_k = stat_k[STAT_BUSY_BIT];
  assign wel_k = stat_k[STAT_WEL_BIT];

  assign frame_rst = cs_n_i || !rst_n_i;

  // marks the first edge of each frame, so no select edge is needed on the link clock
  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // next link state, one step per rising edge
  always_comb begin
    c = lq;
    if (fresh_q) begin
      c.ph = LK_CMD;
      c.cnt = '0;
    end
    ld = c;
    ld.wr_ok = 1'b0;
    buf_we = 1'b0;
    bit_in = {c.sh[22:0], si_i};
    cmd = bit_in[7:0] & OPC_MASK;
    ld.cnt = (c.cnt == BYTE_BITS_LAST) ? 5'h00 : 5'(c.cnt + 5'h01);
    unique case (c.ph)
      LK_CMD: begin
        ld.sh = bit_in;
        if (c.cnt == BYTE_BITS_LAST) begin
          if (cmd == OPC_STAT) begin
            ld.ph = LK_SDATA;
          end else if (busy_k) begin
            ld.ph = LK_IGN;
          end else if (cmd == OPC_READ) begin
            ld.ph = LK_ADDR;
            ld.is_wr = 1'b0;
          end else if (cmd == OPC_WRITE) begin
            ld.ph = wel_k ? LK_ADDR : LK_IGN;
            ld.is_wr = 1'b1;
          end else if (cmd == OPC_SET_WRITE_LATCH_CMD) begin
            ld.set_write_latch_cmd_t = !c.set_write_latch_cmd_t;
            ld.ph = LK_IGN;
          end else begin
            ld.ph = LK_IGN;
          end
        end
      end
      LK_ADDR: begin
        ld.sh = bit_in;
        ld.cnt = 5'(c.cnt + 5'h01);
        if (c.cnt == ADDR_BITS_LAST) begin
          // bits 23 to 17 are dropped
          ld.cnt = '0;
          ld.addr = bit_in[ADDR_W-1:0];
          ld.wptr = bit_in[PAGE_W-1:0];
          ld.wpage = bit_in[ADDR_W-1:PAGE_W];
          ld.ph = c.is_wr ? LK_WDATA : LK_RDATA;
        end
      end
      LK_RDATA: begin
        // input not shifted any more
        if (c.cnt == BYTE_BITS_LAST) begin
          ld.addr = ADDR_W'(c.addr + 17'h00001);
        end
      end
      LK_WDATA: begin
        ld.sh = bit_in;
        if (c.cnt == BYTE_BITS_LAST) begin
          buf_we = 1'b1;
          ld.wptr = PAGE_W'(c.wptr + 7'h01);
          ld.wr_ok = 1'b1;
        end
      end
      LK_SDATA: begin
        ld.sh = c.sh;
      end
      LK_IGN: begin
        // held until select rises
        ld.cnt = c.cnt;
      end
    endcase
  end

  // link register, rising edges only
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lq <= '{ph: LK_IGN, cnt: '0, sh: '0, addr: '0, is_wr: 1'b0, wptr: '0, wpage: '0,
              wr_ok: 1'b0, set_write_latch_cmd_t: 1'b0};
    end else begin
      lq <= ld;
    end
  end

  // array and page buffer; read data always belongs to the next address
  sepa_mem u_mem (
    .sck_i(sck_i),
    .buf_we_i(buf_we),
    .buf_idx_i(c.wptr),
    .buf_data_i(bit_in[7:0]),
    .rd_addr_i(ld.addr),
    .rd_data_o(mem_rd),
    .sys_clk_i(sys_clk_i),
    .prog_en_i(sq.st == WC_COPY),
    .prog_page_i(sq.page),
    .prog_idx_i(sq.idx)
  );

  // next output bit, loaded at each byte start
  always_comb begin
    od = oq;
    if ((lq.ph == LK_RDATA || lq.ph == LK_SDATA) && lq.cnt == 5'h00) begin
      od.oe = 1'b1;
      od.so = (lq.ph == LK_RDATA) ? mem_rd[7] : stat_k[7];
      od.osh = (lq.ph == LK_RDATA) ? {mem_rd[6:0], 1'b0} : {stat_k[6:0], 1'b0};
    end else begin
      od.so = oq.osh[7];
      od.osh = {oq.osh[6:0], 1'b0};
    end
  end

  // output changes on falling edges, released whenever select is high
  always_ff @(negedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      oq <= '{so: 1'b0, oe: 1'b0, osh: 8'h00};
    end else begin
      oq <= od;
    end
  end

  assign so_o = oq.so;
  assign so_oe_o = oq.oe;

  // ---------------- checks ----------------

  chk_latch_clear_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sq.st == WC_WAIT && sq.wait_cnt == WAIT_LAST && !set_write_latch_cmd_ev) |=> (!sq.wel && !sq.busy))
    else $error("write latch not cleared at end of write cycle");

  chk_cycle_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sq.st == WC_IDLE && cs_rise && wrok_s && sq.wel && !prot) |=> sq.busy [*8])
    else $error("write cycle did not start at select rise");

  chk_no_prot_prog: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sq.st == WC_COPY) |-> !sepa_prot({bp_hi_s, bp_lo_s}, sq.page))
    else $error("protected page programmed");

  chk_cycle_needs_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(sq.busy) |-> $past(sq.wel))
    else $error("write cycle without write latch");

  chk_status_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sq.busy |-> sq.stat == STAT_BUSY_ALL) and (!sq.busy |-> !sq.stat[STAT_BUSY_BIT]))
    else $error("status byte does not match busy state");

  chk_full_page: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(sq.st == WC_WAIT) |-> $past(sq.idx) == PAGE_IDX_LAST)
    else $error("page copy shorter than a page");

  chk_busy_ignore: assert property (@(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (c.ph == LK_CMD && c.cnt == BYTE_BITS_LAST && busy_k && cmd != OPC_STAT) |=> lq.ph == LK_IGN)
    else $error("command accepted during write cycle");

  chk_nolatch_write: assert property (@(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (c.ph == LK_CMD && c.cnt == BYTE_BITS_LAST && cmd == OPC_WRITE && !busy_k && !wel_k)
      |=> (lq.ph == LK_IGN) ##1 (lq.ph == LK_IGN && !lq.wr_ok))
    else $error("write without latch not discarded");

  chk_page_wrap: assert property (@(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (c.ph == LK_WDATA && c.cnt == BYTE_BITS_LAST)
      |=> (lq.wptr == PAGE_W'($past(c.wptr) + 7'h01)) && $stable(lq.wpage))
    else $error("page offset did not step within the page");

  chk_read_step: assert property (@(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (c.ph == LK_RDATA && c.cnt == BYTE_BITS_LAST) |=> lq.addr == ADDR_W'($past(c.addr) + 17'h00001))
    else $error("read address did not step");

  chk_addr_low_bits: assert property (@(posedge sck_i) disable iff (!rst_n_i || cs_n_i)
    (c.ph == LK_ADDR && c.cnt == ADDR_BITS_LAST) |=> lq.addr == $past(bit_in[ADDR_W-1:0]))
    else $error("read address not taken from low address bits");

endmodule

// [design/sepa_pkg.sv]
package sepa_pkg;

  // array geometry
  localparam int ADDR_W = 17;                // used address bits
  localparam int ARRAY_BYTES = 131072;       // whole array, power of two so the counter wraps by itself
  localparam int PAGE_W = 7;                 // offset bits inside a page
  localparam int PAGE_BYTES = 128;           // one page
  localparam int PAGE_NUM_W = 10;            // page number bits
  localparam logic [4:0] ADDR_BITS_LAST = 5'h17;  // 24 address bits received, index of the last
  localparam logic [4:0] BYTE_BITS_LAST = 5'h07;  // last bit of a byte
  localparam logic [PAGE_W-1:0] PAGE_IDX_LAST = 7'h7F;

  // opcodes, bit 3 masked off before compare
  localparam logic [7:0] OPC_MASK = 8'hF7;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] OPC_STAT = 8'h05;

  // status byte layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic [7:0] STAT_BUSY_ALL = 8'hFF;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // self-timed write cycle
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int WR_CYCLE_NS = 100000;
  localparam int WR_CYCLE_CYC = (WR_CYCLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int WAIT_W = 20;

  // link side sequencer and write-cycle sequencer
  typedef enum logic [2:0] {LK_CMD, LK_ADDR, LK_RDATA, LK_SDATA, LK_WDATA, LK_IGN} sepa_link_e;
  typedef enum logic [1:0] {WC_IDLE, WC_COPY, WC_WAIT} sepa_wc_e;

endpackage

// [design/sepa_sync.sv]
`timescale 1ns/1ps
module sepa_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;  // first stage, read only by the second

  // two flops; multi-bit use only for bits that may settle independently
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// [design/sepa_mem.sv]
`timescale 1ns/1ps
module sepa_mem (
  // link side: page buffer fill and array read
  input wire logic sck_i,
  input wire logic buf_we_i,
  input wire logic [sepa_pkg::PAGE_W-1:0] buf_idx_i,
  input wire logic [7:0] buf_data_i,
  input wire logic [sepa_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // system side: page copy into the array
  input wire logic sys_clk_i,
  input wire logic prog_en_i,
  input wire logic [sepa_pkg::PAGE_NUM_W-1:0] prog_page_i,
  input wire logic [sepa_pkg::PAGE_W-1:0] prog_idx_i
);
  import sepa_pkg::*;

  logic [7:0] array_m [ARRAY_BYTES];  // written only by the system clock
  logic [7:0] page_m [PAGE_BYTES];    // written only by the link clock

  // link side: the array is read on every rising edge, also while a copy runs; only read frames use the data
  always_ff @(posedge sck_i) begin
    if (buf_we_i) begin
      page_m[buf_idx_i] <= buf_data_i;
    end
    rd_data_o <= array_m[rd_addr_i];
  end

  // system side: buffer is frozen during the copy, frame has ended
  always_ff @(posedge sys_clk_i) begin
    if (prog_en_i) begin
      array_m[{prog_page_i, prog_idx_i}] <= page_m[prog_idx_i];
    end
  end

endmodule

// [tb/sepa_spi_master.sv]
`timescale 1ns/1ps
// behavioural link master, clock idle low, msb first
module sepa_spi_master (
  // link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  localparam realtime HALF = 62.5; // half of the 125 ns link period
  int gap_ns = 0; // extra clock-low time between bytes, models a slow master

  // idle: clock parked low, frame closed
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // fresh select fall opens every frame
  task automatic start();
    cs_n_o = 1'b0;
    #(HALF);
  endtask

  // shift nbits of tx, capture so at each rising edge
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_o = tx[i];
      #(HALF);
      sck_o = 1'b1;
      rx[i] = so_i;
      #(HALF);
      sck_o = 1'b0;
    end
    // released line must not keep its last value
    si_o = ~si_o;
    #(gap_ns);
  endtask

  // close in the clock-low time right after the last bit
  task automatic stop();
    #(HALF / 2);
    cs_n_o = 1'b1;
    #(HALF);
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
// self-checking bench: link master model drives the pins, array model predicts reads
module tb_top;
  import sepa_pkg::*;
  logic sys_clk; // 25 MHz system clock
  logic rst_n; // async reset
  logic sck, cs_n, si, so, so_oe; // link wires
  logic wp_n, bp_lo, bp_hi, arm; // protection pins
  logic busy, wlat, swok; // state seen by the system
  logic [7:0] rx; // last byte captured from so
  logic [7:0] mem_m [int]; // expected array contents
  logic prot; // page expected to be protected
  logic [16:0] aa; // page address under test
  int error_cnt = 0;
  int n_compared = 0;

  // short write cycle keeps the run brief, still long enough to poll
  sepa_top #(.WR_CYCLE_CYC(200)) u_sepa_top (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n), .block_protect_lo_i(bp_lo),
    .block_protect_hi_i(bp_hi), .hw_protect_arm_bit_i(arm), .busy_o(busy),
    .write_latch_o(wlat), .status_write_ok_o(swok));
  sepa_spi_master m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

  // compare one value, count it, report at once
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // gap so the system side sees the select edge
  task automatic pause();
    repeat (10) @(negedge sys_clk);
  endtask
  // opcode plus 24-bit address, ignored top bits filled with junk
  task automatic head(input logic [7:0] opc, input logic [16:0] a);
    m.start();
    m.xfer(opc, 8, rx);
    m.xfer({7'h55, a[16]}, 8, rx);
    m.xfer(a[15:8], 8, rx);
    m.xfer(a[7:0], 8, rx);
  endtask
  // one-byte command in its own frame
  task automatic cmd(input logic [7:0] opc);
    m.start();
    m.xfer(opc, 8, rx);
    m.stop();
    pause();
  endtask
  task automatic stat_chk(input logic [7:0] opc, input logic [7:0] exp);
    m.start();
    m.xfer(opc, 8, rx);
    m.xfer(8'h00, 8, rx);
    m.stop();
    check(rx, exp);
    pause();
  endtask
  // random data bytes; model follows only when the write should land
  task automatic page_write(input logic [7:0] opc, input logic [16:0] a, input int n, input bit ok);
    logic [7:0] d;
    head(opc, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xfer(d, 8, rx);
      if (ok) mem_m[int'({a[16:7], 7'(int'(a[6:0]) + i)})] = d;
    end
    m.stop();
  endtask
  // after a write frame: busy or not, poll, sneak a write in, wait bounded
  task automatic settle(input logic exp);
    int k;
    pause();
    check(busy, exp);
    if (exp) begin
      stat_chk(8'h05, 8'hFF);
      page_write(8'h02, 17'h00000, 2, 0);
      cmd(8'h06);
      for (k = 0; k < 1000 && busy !== 1'b0; k++) begin
        @(negedge sys_clk);
      end
      check({7'h00, k < 1000}, 8'h01);
      check(wlat, 1'b0);
      pause();
      check(busy, 1'b0);
    end
  endtask
  // read n bytes with random junk on si, then close
  task automatic read_chk(input logic [7:0] opc, input logic [16:0] a, input int n);
    head(opc, a);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'($urandom), 8, rx);
      check(rx, mem_m[(int'(a) + i) % ARRAY_BYTES]);
    end
    check(so_oe, 1'b1);
    m.stop();
    check(so_oe, 1'b0);
    pause();
  endtask

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // watchdog, well beyond the expected run of under 1 ms
  initial begin
    #2000000;
    error_cnt++;
    $display("Error at %0t ns: seen %h expected %h", $time, 1'b0, 1'b1);
    results();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    bp_lo = 1'b0;
    bp_hi = 1'b0;
    arm = 1'b0;
    void'($urandom(63));
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    pause();
    check(busy, 1'b0);
    check(wlat, 1'b0);
    check(swok, 1'b0);
    $display("test reset done");
    // permission table over latch, arm bit and pin
    for (int l = 0; l < 2; l++) begin
      if (l == 1) cmd(8'h0E);
      for (int c = 0; c < 4; c++) begin
        arm = c[1];
        wp_n = c[0];
        pause();
        check(swok, l[0] & (~c[1] | c[0]));
        stat_chk(8'h0D, {c[1], 3'b000, bp_hi, bp_lo, l[0], 1'b0});
      end
    end
    arm = 1'b0;
    wp_n = 1'b1;
    $display("test permission done");
    // wrapping page write, then a plain full page
    check(wlat, 1'b1);
    page_write(8'h0A, 17'h1FFFE, 130, 1);
    settle(1'b1);
    cmd(8'h06);
    page_write(8'h02, 17'h00000, 128, 1);
    settle(1'b1);
    $display("test page write done");
    read_chk(8'h0B, 17'h1FF80, 132);
    $display("test read wrap done");
    // latch clear: write dropped, next frame still served
    m.gap_ns = 300;
    page_write(8'h02, 17'h00000, 4, 0);
    settle(1'b0);
    read_chk(8'h03, 17'h00000, 4);
    m.gap_ns = 0;
    $display("test unlatched write done");
    // select raised in mid-byte: nothing programmed
    cmd(8'h06);
    head(8'h02, 17'h00100);
    m.xfer(8'hA5, 8, rx);
    m.xfer(8'h5A, 3, rx);
    m.stop();
    settle(1'b0);
    $display("test partial byte done");
    // every protect level against three pages
    for (int lv = 0; lv < 4; lv++) begin
      bp_hi = lv[1];
      bp_lo = lv[0];
      for (int j = 0; j < 3; j++) begin
        aa = (j == 0) ? 17'h04000 : (j == 1) ? 17'h14000 : 17'h1C000;
        prot = (lv == 3) || (lv == 2 && j > 0) || (lv == 1 && j == 2);
        cmd(8'h06);
        page_write(8'h02, aa, 1, 0);
        settle(~prot);
        check(wlat, prot);
      end
    end
    $display("test protect levels done");
    results();
  end
endmodule
